// ==== ldc_config_latch.sv ====
// module: configuration latch, pwm timing and apb access of the led driver
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ldc_config_latch
	import ldc_pkg::*;
#(
	parameter int IDLE_CYCLES = LATCH_MIN_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from the display controller
	input wire logic config_serial_clock,
	input wire logic configSerialData,
	input wire logic grayscale_latch_strobe,
	input wire logic [GROUPS-1:0] group_pwm_clock,
	input wire logic output_blank_n,
	// grayscale values from the grayscale latch
	input wire logic [GS_BITS-1:0] grayscaleValues,
	// to the current sinks
	output logic [CHANNELS-1:0] channelOn,
	output logic [CHANNELS*DRIVE_W-1:0] channelDrive,
	output logic [TRIM_BITS-1:0] currentTrim,
	output logic [BRIGHT_BITS-1:0] groupBrightness,
	output logic [FC_W-1:0] functionControl
);
	// ****************************************
	// functions
	// ****************************************
	// per-channel drive code: range bit above trim times brightness
	function automatic logic [DRIVE_W-1:0] scaleDrive(input logic rangeHigh, input logic [TRIM_W-1:0] trim,
		input logic [BRIGHT_W-1:0] bright);
		logic [TRIM_W+BRIGHT_W-1:0] prod;
		prod = trim * bright;
		return {rangeHigh, prod};
	endfunction : scaleDrive

	function automatic logic [11:0] countEnd(input ldc_mode_t m);
		case (m)
			MODE_10: return CNT_END_10;
			MODE_8: return CNT_END_8;
			default: return CNT_END_12;
		endcase
	endfunction : countEnd

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [3:0] ctlSync;
	logic [3:0] ctlRise;
	logic [GROUPS-1:0] grpSync;
	logic [GROUPS-1:0] grpRise;
	logic dataSync;

	ldc_pin_sync #(.W(4)) u_ctlSync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pinIn({output_blank_n, grayscale_latch_strobe, configSerialData, config_serial_clock}),
		.pinSync(ctlSync),
		.pinRise(ctlRise)
	);
	ldc_pin_sync #(.W(GROUPS)) u_grpSync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pinIn(group_pwm_clock),
		.pinSync(grpSync),
		.pinRise(grpRise)
	);

	wire sckRise = ctlRise[0];
	assign dataSync = ctlSync[1];
	wire strobeRise = ctlRise[2];
	wire blankLevel = ctlSync[3];

	// ****************************************
	// configuration shift register and idle timer
	// ****************************************
	localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);
	logic [CFG_BITS-1:0] cfgShift;
	logic [CFG_BITS-1:0] cfgLatch;
	logic cfgLoaded;
	logic [IDLE_W-1:0] idleCount;
	ldc_timer_t timerState;
	wire latchPulse = (timerState == TIMER_ARMED) && !sckRise && (idleCount == IDLE_LAST);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cfgShift <= '0;
		else if (sckRise)
			cfgShift <= {cfgShift[CFG_BITS-2:0], dataSync};
	end

	// the latch waits out the minimum idle time, so a slow but live transfer is never cut in two
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timerState <= TIMER_IDLE;
			idleCount <= '0;
		end
		else
		begin
			case (timerState)
				TIMER_IDLE:
				begin
					if (sckRise)
					begin
						timerState <= TIMER_ARMED;
						idleCount <= '0;
					end
				end
				TIMER_ARMED:
				begin
					if (sckRise)
						idleCount <= '0;
					else if (latchPulse)
						timerState <= TIMER_IDLE;
					else
						idleCount <= idleCount + 1'b1;
				end
				default: timerState <= TIMER_IDLE;
			endcase
		end
	end

	// power-up contents are cleared here; the controller still must load before enabling outputs
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfgLatch <= '0;
			cfgLoaded <= 1'b0;
		end
		else if (latchPulse)
		begin
			cfgLatch <= cfgShift;
			cfgLoaded <= 1'b1;
		end
	end

	// ****************************************
	// latch fields
	// ****************************************
	ldc_fc_t fc;
	ldc_mode_t mode;
	assign currentTrim = cfgLatch[TRIM_LSB +: TRIM_BITS];
	assign groupBrightness = cfgLatch[BRIGHT_LSB +: BRIGHT_BITS];
	assign functionControl = cfgLatch[FC_LSB +: FC_W];
	assign fc = ldc_fc_t'(functionControl);
	assign mode = !fc.counterMode[1] ? MODE_12 : (fc.counterMode[0] ? MODE_8 : MODE_10);
	wire [11:0] cntEnd = countEnd(mode);

	// ****************************************
	// apb slave
	// ****************************************
	ldc_apb_req_t req;
	logic softBlank;
	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	wire hitCtrl = (req.addr == ADDR_CTRL);
	wire hitFunc = (req.addr == ADDR_FUNC);
	wire hitBright = (req.addr == ADDR_BRIGHT);
	wire hitCount = (req.addr == ADDR_COUNT);
	wire mapped = hitCtrl | hitFunc | hitBright | hitCount;
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	logic [11:0] groupCount [GROUPS];
	wire [31:0] readMux = hitCtrl ? 32'(softBlank) :
		hitFunc ? ((32'(cfgLoaded) << FUNC_LOADED_BIT) | 32'(functionControl)) :
		hitBright ? 32'(groupBrightness) :
		hitCount ? 32'(groupCount[0]) : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = accessPhase && !mapped;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h0000_0000;
			softBlank <= 1'b1;
		end
		else
		begin
			if (setupPhase && !req.write)
				prdata <= readMux;
			if (accessPhase && req.write && hitCtrl)
				softBlank <= req.wdata[CTRL_BLANK_BIT];
		end
	end

	// ****************************************
	// grayscale counters, one per colour group
	// ****************************************
	// blank pin, software blank and the timing-reset strobe all restart modulation the same way
	wire blankHold = !blankLevel || softBlank;
	wire restartPulse = fc.timingReset && strobeRise;
	logic [GROUPS-1:0] active;
	logic [GROUPS-1:0] done;

	genvar g;
	generate
		for (g = 0; g < GROUPS; g++)
		begin : gen_group
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					groupCount[g] <= '0;
					active[g] <= 1'b0;
					done[g] <= 1'b0;
				end
				else if (blankHold || restartPulse)
				begin
					groupCount[g] <= '0;
					active[g] <= 1'b0;
					done[g] <= 1'b0;
				end
				else if (grpRise[g] && !done[g])
				begin
					if (!active[g])
						active[g] <= 1'b1;
					else if (groupCount[g] >= cntEnd)
					begin
						groupCount[g] <= '0;
						done[g] <= !fc.autoRepeat;
					end
					else
						groupCount[g] <= groupCount[g] + 1'b1;
				end
			end
		end
	endgenerate

	// ****************************************
	// channel outputs
	// ****************************************
	logic [CHANNELS-1:0] next_channelOn;
	logic [CHANNELS*DRIVE_W-1:0] next_channelDrive;
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++)
		begin : gen_chan
			localparam int GRP = c % GROUPS;
			// values above the width are masked, so FFFh cannot stretch past the period
			wire [GS_W-1:0] gsRaw = grayscaleValues[c*GS_W +: GS_W];
			wire [GS_W-1:0] gsVal = gsRaw & cntEnd;
			assign next_channelOn[c] = !blankHold && active[GRP] && !done[GRP] && (groupCount[GRP] < gsVal);
			assign next_channelDrive[c*DRIVE_W +: DRIVE_W] = scaleDrive(fc.trimRange[GRP],
				currentTrim[c*TRIM_W +: TRIM_W], groupBrightness[GRP*BRIGHT_W +: BRIGHT_W]);
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			channelOn <= '0;
			channelDrive <= '0;
		end
		else
		begin
			channelOn <= next_channelOn;
			channelDrive <= next_channelDrive;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_latch_copy;
		@(posedge clk_sys) disable iff (sys_rst)
		latchPulse |=> (cfgLatch == $past(cfgShift)) && cfgLoaded;
	endproperty
	a_latch_copy: assert property (p_latch_copy) else $error("latch did not take shift register");

	property p_latch_idle;
		@(posedge clk_sys) disable iff (sys_rst)
		sckRise |=> !latchPulse;
	endproperty
	a_latch_idle: assert property (p_latch_idle) else $error("latch pulse right after clock edge");

	property p_blank_off;
		@(posedge clk_sys) disable iff (sys_rst)
		blankHold |=> (channelOn == '0);
	endproperty
	a_blank_off: assert property (p_blank_off) else $error("output on during blank");

	property p_trim_field;
		@(posedge clk_sys) disable iff (sys_rst)
		latchPulse |=> currentTrim[TRIM_W-1:0] == $past(cfgShift[TRIM_W-1:0]);
	endproperty
	a_trim_field: assert property (p_trim_field) else $error("trim field misplaced");

	property p_bright_field;
		@(posedge clk_sys) disable iff (sys_rst)
		latchPulse |=> groupBrightness == $past(cfgShift[BRIGHT_LSB +: BRIGHT_BITS]);
	endproperty
	a_bright_field: assert property (p_bright_field) else $error("brightness field misplaced");

	property p_once;
		@(posedge clk_sys) disable iff (sys_rst)
		done[0] && !blankHold && !restartPulse |=> done[0] && (channelOn[0] == 1'b0);
	endproperty
	a_once: assert property (p_once) else $error("group restarted without repeat");

	property p_repeat;
		@(posedge clk_sys) disable iff (sys_rst)
		fc.autoRepeat && grpRise[0] && active[0] && (groupCount[0] == cntEnd) && !blankHold && !restartPulse
			|=> (groupCount[0] == '0) && !done[0];
	endproperty
	a_repeat: assert property (p_repeat) else $error("auto repeat did not wrap");

	property p_dtr;
		@(posedge clk_sys) disable iff (sys_rst)
		restartPulse |=> (groupCount[0] == '0) && !active[0] ##1 (channelOn == '0);
	endproperty
	a_dtr: assert property (p_dtr) else $error("timing reset did not clear");

	property p_no_dtr;
		@(posedge clk_sys) disable iff (sys_rst)
		!fc.timingReset && strobeRise && active[0] && !blankHold && !grpRise[0] |=> active[0] && $stable(groupCount[0]);
	endproperty
	a_no_dtr: assert property (p_no_dtr) else $error("strobe disturbed counter");

	property p_width;
		@(posedge clk_sys) disable iff (sys_rst)
		(mode == MODE_8) && $stable(mode) |-> groupCount[0] <= CNT_END_8;
	endproperty
	a_width: assert property (p_width) else $error("8-bit counter overran");
endmodule : ldc_config_latch

// ==== ldc_ctrl_model.sv ====
// model: display controller driving serial, strobe, group clock and blank pins
`timescale 1ns/1ps
module ldc_ctrl_model (
	// clock
	input wire logic clk_sys,
	// commands from the bench, each go a one-cycle pulse
	input wire logic [198:0] frameBits,
	input wire logic [7:0] frameHi,
	input wire logic [7:0] frameLo,
	input wire logic frameGo,
	input wire logic [2:0] clockMask,
	input wire logic [11:0] clockCount,
	input wire logic clockGo,
	input wire logic strobeGo,
	input wire logic blankCmd,
	output logic busy = 1'b0,
	// pins toward the driver
	output logic config_serial_clock = 1'b0,
	output logic configSerialData = 1'b0,
	output logic grayscale_latch_strobe = 1'b0,
	output logic [2:0] group_pwm_clock = 3'b000,
	output logic output_blank_n = 1'b0
);
	// ********************************
	// blank level follows the bench one cycle later
	// ********************************
	always @(posedge clk_sys)
		output_blank_n <= blankCmd;
	// ********************************
	// sequencer, one command at a time, busy until it ends
	// ********************************
	// link clock of 125 ns runs free of clk_sys and stands still between frames
	always @(posedge clk_sys)
	begin
		if (frameGo)
		begin
			busy <= 1'b1;
			for (int i = int'(frameHi); i >= int'(frameLo); i--)
			begin
				configSerialData <= frameBits[i];
				#62.5 config_serial_clock <= 1'b1;
				#62.5 config_serial_clock <= 1'b0;
			end
			// released data line shows the inverse, never a stale bit
			#62.5 configSerialData <= ~frameBits[frameLo];
			@(posedge clk_sys);
			busy <= 1'b0;
		end
		else if (clockGo)
		begin
			busy <= 1'b1;
			repeat (clockCount)
			begin
				group_pwm_clock <= clockMask;
				repeat (3) @(posedge clk_sys);
				group_pwm_clock <= 3'b000;
				repeat (3) @(posedge clk_sys);
			end
			busy <= 1'b0;
		end
		else if (strobeGo)
		begin
			busy <= 1'b1;
			grayscale_latch_strobe <= 1'b1;
			repeat (4) @(posedge clk_sys);
			grayscale_latch_strobe <= 1'b0;
			repeat (4) @(posedge clk_sys);
			busy <= 1'b0;
		end
	end
endmodule : ldc_ctrl_model

// ==== ldc_pin_sync.sv ====
// module: two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
module ldc_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins and results
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinSync,
	output logic [W-1:0] pinRise
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// edge is found from stages two and three, never on the metastable first stage
	assign pinSync = stage2;
	assign pinRise = stage2 & ~stage3;
endmodule : ldc_pin_sync

// ==== ldc_pkg.sv ====
// package: constants and types of the configuration latch
package ldc_pkg;
	// ****************************************
	// latch layout
	// ****************************************
	localparam int CHANNELS = 24;
	localparam int GROUPS = 3;
	localparam int TRIM_W = 7;
	localparam int BRIGHT_W = 8;
	localparam int FC_W = 7;
	localparam int TRIM_LSB = 0;
	localparam int TRIM_BITS = 168;
	localparam int BRIGHT_LSB = 168;
	localparam int BRIGHT_BITS = 24;
	localparam int FC_LSB = 192;
	localparam int CFG_BITS = 199;
	localparam int GS_W = 12;
	localparam int GS_BITS = 288;
	localparam int DRIVE_W = 16;
	// ****************************************
	// timing
	// ****************************************
	localparam int LATCH_MIN_MS = 3;
	localparam int LATCH_MAX_MS = 7;
	localparam int CLK_MHZ = 250;
	localparam int LATCH_MIN_CYCLES = LATCH_MIN_MS * CLK_MHZ * 1000;
	localparam int LATCH_MAX_CYCLES = LATCH_MAX_MS * CLK_MHZ * 1000;
	// ****************************************
	// counter ends per mode
	// ****************************************
	localparam logic [11:0] CNT_END_12 = 12'hFFF;
	localparam logic [11:0] CNT_END_10 = 12'h3FF;
	localparam logic [11:0] CNT_END_8 = 12'h0FF;
	// ****************************************
	// apb map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FUNC = 8'h04;
	localparam logic [7:0] ADDR_BRIGHT = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;
	localparam int CTRL_BLANK_BIT = 0;
	localparam int FUNC_LOADED_BIT = 8;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {MODE_12, MODE_10, MODE_8} ldc_mode_t;
	typedef enum logic {TIMER_IDLE, TIMER_ARMED} ldc_timer_t;
	typedef struct packed {
		logic [1:0] counterMode;
		logic timingReset;
		logic autoRepeat;
		logic [2:0] trimRange;
	} ldc_fc_t;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [31:0] wdata;
	} ldc_apb_req_t;
endpackage : ldc_pkg

// ==== test_led_driver_config_latch.sv ====
// testbench: configuration latch against the controller model
`timescale 1ns/1ps
module test_led_driver_config_latch
	import ldc_pkg::*;
;
	// short idle time keeps the run small
	localparam int IDLE = 200;
	// mode 8 bit, no repeat, no timing reset, ranges 101
	localparam ldc_fc_t F1 = 7'h65;
	// mode 10 bit, timing reset, repeat, ranges 010
	localparam ldc_fc_t F2 = 7'h5A;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [GS_BITS-1:0] grayscaleValues = '0;
	logic [31:0] prdata, rd, c0;
	logic pready, pslverr, er;
	logic config_serial_clock, configSerialData, grayscale_latch_strobe, output_blank_n;
	logic [2:0] group_pwm_clock;
	logic [198:0] frameBits = '0;
	logic [7:0] frameHi = 8'h00;
	logic [7:0] frameLo = 8'h00;
	logic frameGo = 1'b0;
	logic [2:0] clockMask = 3'b000;
	logic [11:0] clockCount = 12'h000;
	logic clockGo = 1'b0;
	logic strobeGo = 1'b0;
	logic blankCmd = 1'b0;
	logic busy;
	logic [CHANNELS-1:0] channelOn;
	logic [CHANNELS*DRIVE_W-1:0] channelDrive;
	logic [TRIM_BITS-1:0] currentTrim;
	logic [BRIGHT_BITS-1:0] groupBrightness;
	logic [FC_W-1:0] functionControl;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	ldc_config_latch #(.IDLE_CYCLES(IDLE)) ldc_config_latch_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .config_serial_clock(config_serial_clock),
		.configSerialData(configSerialData), .grayscale_latch_strobe(grayscale_latch_strobe),
		.group_pwm_clock(group_pwm_clock), .output_blank_n(output_blank_n), .grayscaleValues(grayscaleValues),
		.channelOn(channelOn), .channelDrive(channelDrive), .currentTrim(currentTrim),
		.groupBrightness(groupBrightness), .functionControl(functionControl));
	ldc_ctrl_model ldc_ctrl_model_inst (.clk_sys(clk_sys), .frameBits(frameBits), .frameHi(frameHi),
		.frameLo(frameLo), .frameGo(frameGo), .clockMask(clockMask), .clockCount(clockCount), .clockGo(clockGo),
		.strobeGo(strobeGo), .blankCmd(blankCmd), .busy(busy), .config_serial_clock(config_serial_clock),
		.configSerialData(configSerialData), .grayscale_latch_strobe(grayscale_latch_strobe),
		.group_pwm_clock(group_pwm_clock), .output_blank_n(output_blank_n));
	always #2 clk_sys = ~clk_sys;
	// ********************************
	// shared tasks
	// ********************************
	task automatic check(input logic [199:0] got, input logic [199:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : check
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : w
	// go pulses last one cycle; busy is up from the next edge until the command ends
	task automatic wait_model;
		@(posedge clk_sys);
		frameGo <= 1'b0;
		clockGo <= 1'b0;
		strobeGo <= 1'b0;
		@(posedge clk_sys);
		while (busy)
			@(posedge clk_sys);
	endtask : wait_model
	task automatic send_bits(input logic [198:0] f, input int hi, input int lo);
		frameBits <= f;
		frameHi <= 8'(hi);
		frameLo <= 8'(lo);
		frameGo <= 1'b1;
		wait_model();
	endtask : send_bits
	task automatic gclk(input logic [2:0] m, input int n);
		clockMask <= m;
		clockCount <= 12'(n);
		clockGo <= 1'b1;
		wait_model();
	endtask : gclk
	task automatic strobe;
		strobeGo <= 1'b1;
		wait_model();
	endtask : strobe
	// blank rises only once programmed, falls only after modulation ends
	task automatic set_blank(input logic b);
		blankCmd <= b;
		@(posedge clk_sys);
	endtask : set_blank
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	function automatic logic [198:0] mk(input ldc_fc_t fc, input logic [23:0] br, input logic [6:0] t0);
		logic [198:0] f;
		f = '0;
		for (int c = 0; c < CHANNELS; c++)
			f[c*7 +: 7] = t0 + 7'(c);
		f[175:168] = br[7:0];
		f[183:176] = br[15:8];
		f[191:184] = br[23:16];
		f[198:192] = fc;
		return f;
	endfunction : mk
	// split frame: a gap shorter than the idle time must not latch
	task automatic load(input logic [198:0] f);
		send_bits(f, 198, 100);
		w(IDLE / 2);
		send_bits(f, 99, 0);
		w(80);
	endtask : load
	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset;
		check(channelOn, '0, "on in reset");
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(rd, 32'h1, "ctrl reset");
		apb(1'b1, ADDR_BRIGHT, 32'hFFFF_FFFF);
		apb(1'b0, ADDR_BRIGHT, 32'h0);
		check(rd, 32'h0, "bright read only");
		apb(1'b0, 8'h10, 32'h0);
		check({er, rd}, {1'b1, 32'h0}, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_load;
		load(mk(F1, 24'h815AC3, 7'h11));
		check(currentTrim, '0, "early latch");
		w(150);
		check(currentTrim[6:0], 7'h11, "trim red 0");
		check(currentTrim[167:161], 7'h28, "trim blue 7");
		check(groupBrightness, 24'h815AC3, "brightness");
		check(functionControl, F1, "function");
		check({channelDrive[47], channelDrive[31], channelDrive[15]}, 3'b101, "ranges");
		check(channelDrive[14:0], 15'(7'h11) * 15'(8'hC3), "drive scale");
		apb(1'b0, ADDR_FUNC, 32'h0);
		check(rd, {23'h0, 2'b10, F1}, "func reg");
		$display("test load done");
	endtask : t_load
	task automatic t_once;
		grayscaleValues <= {{23{12'hFFF}}, 12'h005};
		apb(1'b1, ADDR_CTRL, 32'h0);
		gclk(3'b111, 3);
		w(8);
		check(channelOn, '0, "blank low");
		set_blank(1'b1);
		gclk(3'b111, 2);
		w(8);
		check(channelOn[1:0], 2'b11, "both on");
		gclk(3'b111, 8);
		w(8);
		check(channelOn[1:0], 2'b10, "short off");
		gclk(3'b111, 240);
		apb(1'b0, ADDR_COUNT, 32'h0);
		c0 = rd;
		strobe();
		apb(1'b0, ADDR_COUNT, 32'h0);
		check({channelOn[1], rd}, {1'b1, c0}, "strobe ignored");
		gclk(3'b111, 10);
		w(8);
		check(channelOn, '0, "8 bit end");
		set_blank(1'b0);
		$display("test single cycle done");
	endtask : t_once
	task automatic t_repeat;
		load(mk(F2, 24'h3CA57E, 7'h40));
		w(150);
		check(functionControl, F2, "function 2");
		check({channelDrive[47], channelDrive[31], channelDrive[15]}, 3'b010, "ranges 2");
		set_blank(1'b1);
		gclk(3'b111, 1000);
		w(8);
		check(channelOn[1:0], 2'b10, "mid period");
		gclk(3'b111, 26);
		w(8);
		check(channelOn[1:0], 2'b11, "repeat");
		strobe();
		w(4);
		check(channelOn, '0, "strobe off");
		apb(1'b0, ADDR_COUNT, 32'h0);
		check(rd, 32'h0, "count cleared");
		// only the red group gets clocks, green must stay off
		gclk(3'b001, 2);
		w(8);
		check(channelOn[1:0], 2'b01, "resume");
		$display("test repeat done");
	endtask : t_repeat
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			final_report();
		end
	end
	initial
	begin
		w(20);
		sys_rst <= 1'b0;
		w(1);
		t_reset();
		t_load();
		t_once();
		t_repeat();
		final_report();
	end
endmodule : test_led_driver_config_latch
